// ===== core/idbs_datapath.v
// Divide and barrel shift datapath with its working register file
`default_nettype none
`include "idbs_defs.vh"
module idbs_datapath (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        reset_n,
	// Shift request
	input  wire        shift_start,
	input  wire [1:0]  shift_op,
	input  wire [3:0]  shift_src_sel,
	input  wire [3:0]  shift_dst_sel,
	input  wire [3:0]  shift_amount,
	// Divide request
	input  wire        div_start,
	input  wire        div_signed,
	input  wire        div_long,
	input  wire [3:0]  divisor_sel,
	input  wire [3:0]  dividend_sel,
	// Register file write port from the rest of the core
	input  wire        wr_en,
	input  wire [3:0]  wr_sel,
	input  wire [15:0] wr_data,
	// Register file read port
	input  wire [3:0]  rd_sel,
	output reg  [15:0] rd_data,
	// Status
	output wire        div_busy,
	output reg         div_done
);
	// One-hot divider states
	localparam ST_IDLE = 2'b01;
	localparam ST_DIV  = 2'b10;

	// Working register file
	reg [15:0] work_reg [0:15];

	// Divider state and its next values
	reg [1:0]  state_q;
	reg [1:0]  state_d;
	reg [4:0]  count_q;
	reg [4:0]  count_d;
	reg [31:0] rem_q;      // Partial remainder, magnitude
	reg [31:0] rem_d;
	reg [31:0] quo_q;      // Low dividend shifting out, quotient shifting in
	reg [31:0] quo_d;
	reg [15:0] dvs_q;      // Divisor magnitude
	reg [15:0] dvs_d;
	reg        qneg_q;
	reg        qneg_d;
	reg        rneg_q;
	reg        rneg_d;
	reg        done_d;

	// Operand fetch and iteration nets
	wire [15:0] shift_res;
	wire [15:0] dvd_hi;
	wire [15:0] dvd_lo;
	wire [31:0] dvd_full;
	wire        dvd_neg;
	wire [31:0] dvd_mag;
	wire [15:0] dvs_raw;
	wire        dvs_neg;
	wire [31:0] dvs_mag;
	wire [31:0] rem_sh;
	wire [32:0] trial;
	wire        trial_ok;
	wire [15:0] quo_last;
	wire [15:0] rem_last;
	wire [15:0] quo_fin;
	wire [15:0] rem_fin;
	wire        is_idle;
	wire        div_take;
	wire        shift_take;
	wire        div_last;
	integer     i;

	// Two's complement magnitude of a possibly negative word
	function [31:0] mag32;
		input [31:0] v;
		input        neg;
		begin
			mag32 = neg ? (~v + 32'h0000_0001) : v;
		end
	endfunction

	// Sign fix-up of a 16-bit result
	function [15:0] neg16;
		input [15:0] v;
		input        neg;
		begin
			neg16 = neg ? (16'h0000 - v) : v;
		end
	endfunction

	idbs_shifter u_shifter (
		.src    (work_reg[shift_src_sel]), // RULE11
		.amount (shift_amount),
		.op     (shift_op),
		.result (shift_res)
	);

	// Dividend pair: odd register is the upper half
	assign dvd_lo   = work_reg[{dividend_sel[3:1], 1'b0}];     // RULE5
	assign dvd_hi   = work_reg[{dividend_sel[3:1], 1'b1}];     // RULE5
	assign dvd_full = div_long ? {dvd_hi, dvd_lo} :
		{{16{div_signed & dvd_lo[15]}}, dvd_lo};            // RULE15
	assign dvd_neg  = div_signed & dvd_full[31];
	assign dvd_mag  = mag32(dvd_full, dvd_neg);
	assign dvs_raw  = work_reg[divisor_sel];                    // RULE4
	assign dvs_neg  = div_signed & dvs_raw[15];
	assign dvs_mag  = mag32({16'h0000, dvs_raw}, dvs_neg);

	// Restoring step; remainder stays below the divisor, so 17 bits suffice
	assign rem_sh   = {rem_q[30:0], quo_q[31]};
	assign trial    = {1'b0, rem_sh} - {17'h0_0000, dvs_q};
	assign trial_ok = ~trial[32];
	assign quo_last = {quo_q[14:0], trial_ok};
	assign rem_last = trial_ok ? trial[15:0] : rem_sh[15:0];
	assign quo_fin  = neg16(quo_last, qneg_q);
	assign rem_fin  = neg16(rem_last, rneg_q);

	// Request acceptance
	assign is_idle    = state_q == ST_IDLE;
	assign div_take   = div_start & is_idle;
	assign shift_take = shift_start & is_idle & ~div_start;
	assign div_last   = (state_q == ST_DIV) && (count_q == 5'h01);
	assign div_busy   = state_q == ST_DIV;                      // RULE16

	always @* begin
		rd_data = work_reg[rd_sel];
	end

	// Divider next-state logic
	always @* begin
		state_d = state_q;
		count_d = count_q;
		rem_d   = rem_q;
		quo_d   = quo_q;
		dvs_d   = dvs_q;
		qneg_d  = qneg_q;
		rneg_d  = rneg_q;
		done_d  = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (div_take) begin // RULE1
					// Work on magnitudes, fix signs at the end
					qneg_d  = dvd_neg ^ dvs_neg;
					rneg_d  = dvd_neg;
					// Upper half preloads the remainder; quotient must fit 16 bits
					rem_d   = {16'h0000, dvd_mag[31:16]};
					quo_d   = {dvd_mag[15:0], 16'h0000};
					dvs_d   = dvs_mag[15:0];
					count_d = `IDBS_DIV_CYCLES; // RULE6 RULE7
					state_d = ST_DIV;
				end
			end
			ST_DIV: begin
				if (trial_ok) begin
					rem_d = trial[31:0];
					quo_d = {quo_q[30:0], 1'b1};
				end else begin
					rem_d = rem_sh;
					quo_d = {quo_q[30:0], 1'b0};
				end
				count_d = count_q - 5'h01;
				if (div_last) begin
					state_d = ST_IDLE;
					done_d  = 1'b1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			count_q <= 5'h00;
		end else begin
			count_q <= count_d;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			rem_q <= 32'h0000_0000;
			quo_q <= 32'h0000_0000;
		end else begin
			rem_q <= rem_d;
			quo_q <= quo_d;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			dvs_q <= 16'h0000;
		end else begin
			dvs_q <= dvs_d;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			qneg_q <= 1'b0;
			rneg_q <= 1'b0;
		end else begin
			qneg_q <= qneg_d;
			rneg_q <= rneg_d;
		end
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			div_done <= 1'b0;
		end else begin
			div_done <= done_d;
		end
	end

	// Register file; later writes win, so results override a core write
	always @(posedge sys_clk) begin
		if (!reset_n) begin
			for (i = 0; i < 16; i = i + 1) begin
				work_reg[i] <= `IDBS_WREG_RESET;
			end
		end else begin
			if (wr_en) begin
				work_reg[wr_sel] <= wr_data;
			end
			if (shift_take) begin
				work_reg[shift_dst_sel] <= shift_res; // RULE8 RULE11
			end
			if (div_last) begin
				work_reg[`IDBS_QUOT_REG] <= quo_fin; // RULE2
				work_reg[`IDBS_REM_REG]  <= rem_fin; // RULE3
			end
		end
	end
endmodule // idbs_datapath
`default_nettype wire

// ===== common/idbs_defs.vh
// Constants and functional notes for the divide and barrel shift datapath
// Functional notes
// RULE1: Four divide modes, signed/unsigned, 32/16 and 16/16
// RULE2: Quotient always goes to work register zero
// RULE3: Remainder always goes to work register one
// RULE4: Divisor read from any named work register
// RULE5: Dividend from even pair, high register upper
// RULE6: One iteration cycle per divisor bit
// RULE7: 32/16 and 16/16 take equal cycles
// RULE8: One-bit and multi-bit shifts, single cycle
// RULE9: Arithmetic right up to 15, sign fill
// RULE10: Left shift up to 15 in one cycle
// RULE11: Shifts register direct source and destination
// RULE12: Arithmetic right shift keeps the sign
// RULE13: Left shift fills low bits with zero
// RULE14: Logical right shift fills high bits zero
// RULE15: 16/16 dividend sign or zero extended
// RULE16: Busy held through whole divide sequence
`ifndef IDBS_DEFS_VH
`define IDBS_DEFS_VH
`define IDBS_QUOT_REG      4'h0
`define IDBS_REM_REG       4'h1
`define IDBS_SH_ASR        2'h0
`define IDBS_SH_LSL        2'h1
`define IDBS_SH_LSR        2'h2
`define IDBS_DIV_CYCLES    5'h10
`define IDBS_WREG_RESET    16'h0000
`endif

// ===== core/idbs_shifter.v
// Single-cycle 16-bit barrel shifter
`default_nettype none
`include "idbs_defs.vh"
module idbs_shifter (
	// Operand
	input  wire [15:0] src,
	input  wire [3:0]  amount,
	input  wire [1:0]  op,
	// Result
	output reg  [15:0] result
);
	always @* begin
		case (op)
			`IDBS_SH_ASR: result = $signed(src) >>> amount; // RULE9 RULE12
			`IDBS_SH_LSL: result = src << amount;           // RULE10 RULE13
			`IDBS_SH_LSR: result = src >> amount;           // RULE14
			default:      result = src;
		endcase
	end
endmodule // idbs_shifter
`default_nettype wire

// ===== test/idbs_datapath_sva.sv
// Checker for the divide and shift datapath ports
`default_nettype none
module idbs_datapath_sva (
	input wire logic        sys_clk, reset_n, shift_start, div_start, wr_en, div_busy, div_done,
	input wire logic [1:0]  shift_op,
	input wire logic [3:0]  shift_dst_sel, shift_amount, rd_sel,
	input wire logic [15:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	logic sh;
	// A core write in the same cycle loses to the shift result; the check still skips it
	assign sh = shift_start && !div_busy && !div_start && !wr_en;
	a_busy_span: assert property (div_start && !div_busy |=> div_busy[*8] ##1 div_busy[*8] ##1 !div_busy)
		else $error("busy span wrong");
	a_busy_cause: assert property ($rose(div_busy) |-> $past(div_start)) else $error("busy without start");
	a_done_at_end: assert property ($fell(div_busy) |-> div_done) else $error("done missing");
	a_done_idle: assert property (!div_busy |=> !div_done) else $error("done while idle");
	a_done_pulse: assert property (div_done |=> !div_done) else $error("done too long");
	a_left_fill: assert property (sh && shift_op == 2'h1 |=> rd_sel != $past(shift_dst_sel)
		|| (rd_data & ~(16'hffff << $past(shift_amount))) == 16'h0) else $error("left fill wrong");
	a_lsr_fill: assert property (sh && shift_op == 2'h2 |=> rd_sel != $past(shift_dst_sel)
		|| (rd_data & ~(16'hffff >> $past(shift_amount))) == 16'h0) else $error("right fill wrong");
	a_asr_sign: assert property (sh && shift_op == 2'h0 |=> rd_sel != $past(shift_dst_sel)
		|| ($signed(rd_data) >>> (15 - $past(shift_amount))) inside {16'h0, 16'hffff}) else $error("sign fill wrong");
endmodule // idbs_datapath_sva
bind idbs_datapath idbs_datapath_sva i_sva (.*);
`default_nettype wire

// ===== test/idbs_core_model.sv
// Decoder model that issues a divide only when the unit is free
`default_nettype none
module idbs_core_model (
	input wire logic sys_clk, div_busy, div_done, want,
	output logic     div_start
);
	timeunit 1ns; timeprecision 1ps;
	initial div_start = 0;
	// One-cycle request; stalls while a divide is in flight
	always @(negedge sys_clk) div_start <= want && !div_busy && !div_done && !div_start;
endmodule // idbs_core_model
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the divide and shift datapath
`default_nettype none
module testbench;
	timeunit 1ns; timeprecision 1ps;
	logic sys_clk = 0, reset_n = 0, shift_start = 0, div_signed = 0, div_long = 0, wr_en = 0, want = 0;
	logic [1:0] shift_op = 0;
	logic [3:0] shift_src_sel = 0, shift_dst_sel = 0, shift_amount = 0, divisor_sel = 0, dividend_sel = 0;
	logic [3:0] wr_sel = 0, rd_sel = 0;
	logic [15:0] wr_data = 0, rd_data, a, b, h;
	logic div_start, div_busy, div_done;
	logic [31:0] dd, q, r;
	int mismatches = 0, checked = 0, seed = 25410, n, i;
	idbs_datapath i_dut (.*);
	idbs_core_model i_core (.*);
	initial forever #2.5 sys_clk = ~sys_clk;
	task chk(logic [15:0] s, e);
		checked++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(logic [3:0] s, logic [15:0] d);
		@(negedge sys_clk) {wr_en, wr_sel, wr_data} = {1'b1, s, d};
		@(negedge sys_clk) wr_en = 0;
	endtask
	function logic [15:0] shx(logic [15:0] v, logic [1:0] o, logic [3:0] k);
		if (o == 2'h0) return $signed(v) >>> k;
		return o == 2'h1 ? v << k : v >> k;
	endfunction
	task give_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#50us mismatches++;
		give_verdict;
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		reset_n = 1;
		for (i = 0; i < 30; i++) begin
			a = $random(seed);
			n = $random(seed);
			wr(n[3:0], a);
			@(negedge sys_clk) {shift_start, shift_op, shift_src_sel, shift_dst_sel, shift_amount, rd_sel} =
				{1'b1, 2'(i % 3), n[3:0], n[7:4], i < 6 ? 4'hf : n[11:8], n[7:4]};
			@(negedge sys_clk) shift_start = 0;
			#1 chk(rd_data, shx(a, shift_op, shift_amount));
		end
		for (i = 0; i < 16; i++) begin
			a = $random(seed) | 1;
			b = $random(seed);
			n = 2 + 2 * (i % 7);
			// Unsigned long high half kept below the divisor so the quotient fits
			h = i[0] ? {16{b[15]}} : i[1] ? b % a : 16'h0;
			dd = {h, b};
			wr(n[3:0], b);
			wr(4'(n + 1), i[1] ? h : ~h);
			wr(4'(n + 2), a);
			if (i[0]) {q, r} = {$signed(dd) / $signed({{16{a[15]}}, a}), $signed(dd) % $signed({{16{a[15]}}, a})};
			else {q, r} = {dd / a, dd % a};
			@(negedge sys_clk) {div_long, div_signed, dividend_sel, divisor_sel} = {2'(i), n[3:0], 4'(n + 2)};
			want <= 1;
			@(posedge div_start);
			@(posedge sys_clk);
			n = 0;
			do begin
				@(posedge sys_clk);
				n++;
				#1;
			end while (div_done !== 1'b1 && n < 40);
			want <= 0;
			chk(n[15:0], 16'h0010);
			@(negedge sys_clk) rd_sel = 0;
			#1 chk(rd_data, q[15:0]);
			rd_sel = 1;
			#1 chk(rd_data, r[15:0]);
		end
		give_verdict;
	end
endmodule // testbench
`default_nettype wire
